// ===== src/ebct_params.svh
`ifndef EBCT_PARAMS_SVH
`define EBCT_PARAMS_SVH
// Operation
// (RULE_01) The counter is an 8-bit up-counter whose count source comes from a three-bit clock select field.
// (RULE_02) Software may read and write the counter at any time, even while it counts.
// (RULE_03) The counter clears on the external clear pin, match A or match B as a two-bit clear select field picks.
// (RULE_04) An overflow sets the overflow flag in the control/status register.
// (RULE_05) The counter holds zero after reset.
// (RULE_06) Match constants A and B are identical 8-bit read/write registers.
// (RULE_07) An external count clock pin can serve as the count source.
// (RULE_08) An external clear pin clears the counter when that clear source is chosen.
// (RULE_09) An external start trigger pin can start counting.
// (RULE_10) The waveform output pin changes level on compare matches.
// (RULE_11) A four-bit output select field can make the output go high on match A and low on match B.
// (RULE_12) The internal clock pick bit in the second control register joins the clock select field.
// (RULE_13) Once set up, the pulse waveform runs on alone, A setting the period and B the width.
// (RULE_14) The timer runs in active and sleep modes and is held in reset in the low-power modes.
// (RULE_15) Match A or B is raised when the counter equals constant A or B.
// (RULE_16) Overflow is the step from all ones back to zero.

// Register byte addresses
`define EBCT_OFS_COUNT 8'h00
`define EBCT_OFS_CONST_A 8'h04
`define EBCT_OFS_CONST_B 8'h08
`define EBCT_OFS_CTRL0 8'h0c
`define EBCT_OFS_CSR 8'h10
`define EBCT_OFS_CTRL1 8'h14
`define EBCT_OFS_IRQ_STAT 8'h18
`define EBCT_OFS_IRQ_MASK 8'h1c

// First control register fields
`define EBCT_CKS_LSB 0
`define EBCT_CCLR_LSB 3
`define EBCT_TRGE_BIT 5
// Control/status register fields
`define EBCT_OS_LSB 0
`define EBCT_OVF_BIT 7
// Second control register fields
`define EBCT_ICKS_BIT 0

// Status / mask bits
`define EBCT_IRQ_OVF 0
`define EBCT_IRQ_CMA 1
`define EBCT_IRQ_CMB 2

`define EBCT_CONST_RESET 8'hff
`define EBCT_COUNT_RESET 8'h00
`endif

// ===== src/ebct_pkg.sv
package ebct_pkg;
    typedef enum logic [1:0] {EBCT_CLR_NONE, EBCT_CLR_A, EBCT_CLR_B, EBCT_CLR_EXT} ebct_clr_e;
    typedef enum logic [1:0] {EBCT_OS_KEEP, EBCT_OS_LOW, EBCT_OS_HIGH, EBCT_OS_TOGGLE} ebct_os_e;
    typedef enum logic {EBCT_RUN_WAIT, EBCT_RUN_GO} ebct_run_e;
endpackage : ebct_pkg

// ===== src/ebct_pin_sync.sv
`timescale 1ns/10ps
module ebct_pin_sync (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_pin,
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    logic [2:0] sh_q;
    logic [2:0] sh_d;
    logic lvl_q;
    logic lvl_d;
    logic [1:0] fill_q;
    logic [1:0] fill_d;
    logic primed;

    // Until the chain holds real samples the level just follows it and no edge is reported,
    // so a pin resting high when reset ends does not fake an edge
    assign primed = (fill_q == 2'h3);

    // Once primed, a change is accepted only once stages two and three agree
    always_comb
    begin
        sh_d = {sh_q[1:0], i_pin};
        fill_d = primed ? fill_q : fill_q + 2'h1;
        lvl_d = !primed ? sh_q[1] : ((sh_q[1] == sh_q[2]) ? sh_q[2] : lvl_q);
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            sh_q <= 3'h0;
            lvl_q <= 1'b0;
            fill_q <= 2'h0;
        end
        else if (i_ce)
        begin
            sh_q <= sh_d;
            lvl_q <= lvl_d;
            fill_q <= fill_d;
        end
    end

    assign o_level = lvl_q;
    assign o_rise = primed & lvl_d & ~lvl_q;
    assign o_fall = primed & ~lvl_d & lvl_q;
endmodule : ebct_pin_sync

// ===== src/ebct_prescaler.sv
`timescale 1ns/10ps
module ebct_prescaler #(
    parameter int WIDTH = 8
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_run,
    output logic [WIDTH-1:0] o_tick
);
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;

    if (WIDTH < 2 || WIDTH > 16)
    begin : g_bad_width
        $error("ebct_prescaler WIDTH out of range");
    end

    always_comb
    begin
        cnt_d = i_run ? cnt_q + {{(WIDTH-1){1'b0}}, 1'b1} : {WIDTH{1'b0}};
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            cnt_q <= {WIDTH{1'b0}};
        end
        else if (i_ce)
        begin
            cnt_q <= cnt_d;
        end
    end

    // Tick k pulses every 2^(k+1) clocks
    genvar k;
    generate
        for (k = 0; k < WIDTH; k = k + 1)
        begin : g_tick
            assign o_tick[k] = i_run & (cnt_q[k:0] == {(k+1){1'b1}});
        end
    endgenerate
endmodule : ebct_prescaler

// ===== src/ebct_timer.sv
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "ebct_params.svh"
module ebct_timer (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_low_power,
    input wire logic i_ext_count_clock_pin,
    input wire logic i_ext_clear_pin,
    input wire logic i_start_trigger_pin,
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic o_wave_out_pin,
    output logic o_irq
);
    import ebct_pkg::*;

    // Low-power modes hold the whole timer except the bus slave in reset
    logic t_rst_n;
    assign t_rst_n = i_rst_n & ~i_low_power; // RULE_14

    function automatic logic rw_hit(input logic [7:0] a, input logic [7:0] ofs);
        rw_hit = (a[7:2] == ofs[7:2]);
    endfunction : rw_hit

    logic ext_clk_lvl;
    logic ext_clk_rise;
    logic ext_clk_fall;
    logic ext_clr_lvl;
    logic ext_clr_rise;
    logic trg_lvl;
    logic trg_rise;
    logic trg_fall;

    ebct_pin_sync u_sync_clk (
        .i_mclk(i_mclk),
        .i_rst_n(t_rst_n),
        .i_ce(i_ce),
        .i_pin(i_ext_count_clock_pin),
        .o_level(ext_clk_lvl),
        .o_rise(ext_clk_rise),
        .o_fall(ext_clk_fall)
    );

    ebct_pin_sync u_sync_clr (
        .i_mclk(i_mclk),
        .i_rst_n(t_rst_n),
        .i_ce(i_ce),
        .i_pin(i_ext_clear_pin),
        .o_level(ext_clr_lvl),
        .o_rise(ext_clr_rise),
        .o_fall()
    );

    ebct_pin_sync u_sync_trg (
        .i_mclk(i_mclk),
        .i_rst_n(t_rst_n),
        .i_ce(i_ce),
        .i_pin(i_start_trigger_pin),
        .o_level(trg_lvl),
        .o_rise(trg_rise),
        .o_fall(trg_fall)
    );

    // Registers
    logic [7:0] count_q, count_d;
    logic [7:0] const_a_q, const_a_d;
    logic [7:0] const_b_q, const_b_d;
    logic [7:0] ctrl0_q, ctrl0_d;
    logic [7:0] csr_q, csr_d;
    logic [7:0] ctrl1_q, ctrl1_d;
    logic [2:0] stat_q, stat_d;
    logic [2:0] mask_q, mask_d;
    logic wave_q, wave_d;
    ebct_run_e run_q, run_d;
    logic cm_a_q, cm_a_d;
    logic cm_b_q, cm_b_d;

    // Bus slave state
    logic aw_held_q, aw_held_d;
    logic [7:0] aw_addr_q, aw_addr_d;
    logic w_held_q, w_held_d;
    logic [31:0] w_data_q, w_data_d;
    logic w_lane0_q, w_lane0_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic irq_q, irq_d;
    logic awready_q, wready_q, arready_q;

    logic [2:0] cks;
    ebct_clr_e clr_sel;
    logic [1:0] os_a;
    logic [1:0] os_b;
    logic icks;
    logic trg_en;
    logic [7:0] ptick;
    logic count_tick;
    logic do_write;
    logic addr_ok;
    logic match_a;
    logic match_b;
    logic ovf_evt;

    assign cks = ctrl0_q[`EBCT_CKS_LSB +: 3]; // RULE_01
    assign clr_sel = ebct_clr_e'(ctrl0_q[`EBCT_CCLR_LSB +: 2]); // RULE_03
    assign trg_en = ctrl0_q[`EBCT_TRGE_BIT];
    assign os_a = csr_q[`EBCT_OS_LSB +: 2];
    assign os_b = csr_q[`EBCT_OS_LSB + 2 +: 2]; // RULE_11
    assign icks = ctrl1_q[`EBCT_ICKS_BIT];

    ebct_prescaler #(
        .WIDTH(8)
    ) u_pre (
        .i_mclk(i_mclk),
        .i_rst_n(t_rst_n),
        .i_ce(i_ce),
        .i_run(run_q == EBCT_RUN_GO),
        .o_tick(ptick)
    );

    // Count source: 000 stops; 001..011 internal rates with the pick bit doubling the divider on 001 and 010 and quadrupling it on 011;
    // 100..111 stop internally except ext pin edges on 101 rise, 110 fall, 111 both
    always_comb
    begin
        count_tick = 1'b0;
        case (cks) // RULE_12
            3'h1: count_tick = icks ? ptick[1] : ptick[0];
            3'h2: count_tick = icks ? ptick[3] : ptick[2];
            3'h3: count_tick = icks ? ptick[7] : ptick[5];
            3'h5: count_tick = ext_clk_rise; // RULE_07
            3'h6: count_tick = ext_clk_fall;
            3'h7: count_tick = ext_clk_rise | ext_clk_fall;
            default: count_tick = 1'b0;
        endcase
        if (run_q != EBCT_RUN_GO)
        begin
            count_tick = 1'b0;
        end
    end

    assign match_a = (count_q == const_a_q); // RULE_15
    assign match_b = (count_q == const_b_q); // RULE_15
    assign ovf_evt = count_tick && (count_q == 8'hff); // RULE_16

    assign addr_ok = 1'b1;
    assign do_write = aw_held_q && w_held_q && !bvalid_q;

    // Timer core and register writes
    always_comb
    begin
        count_d = count_q;
        const_a_d = const_a_q;
        const_b_d = const_b_q;
        ctrl0_d = ctrl0_q;
        csr_d = csr_q;
        ctrl1_d = ctrl1_q;
        mask_d = mask_q;
        wave_d = wave_q;
        run_d = run_q;
        // Match is registered so each compare fires once, on entering the equal value
        cm_a_d = match_a;
        cm_b_d = match_b;
        stat_d = stat_q;

        // Trigger gating: with trigger enabled, counting waits for a trigger edge
        case (run_q)
            EBCT_RUN_WAIT:
            begin
                // Select zero keeps waiting, else a stopped timer would leave waiting before the trigger is armed
                if (cks != 3'h0 && (!trg_en || trg_rise || trg_fall)) // RULE_09
                begin
                    run_d = EBCT_RUN_GO;
                end
            end
            EBCT_RUN_GO:
            begin
                if (cks == 3'h0)
                begin
                    run_d = EBCT_RUN_WAIT;
                end
            end
            default: run_d = EBCT_RUN_WAIT;
        endcase

        if (count_tick)
        begin
            count_d = count_q + 8'h01; // RULE_01
        end
        if ((clr_sel == EBCT_CLR_A && match_a && !cm_a_q) ||
            (clr_sel == EBCT_CLR_B && match_b && !cm_b_q) ||
            (clr_sel == EBCT_CLR_EXT && ext_clr_rise)) // RULE_08
        begin
            count_d = 8'h00; // RULE_03
        end

        // Waveform: A sets period by clearing, B sets width
        if (match_a && !cm_a_q) // RULE_10
        begin
            case (os_a)
                2'h1: wave_d = 1'b0;
                2'h2: wave_d = 1'b1; // RULE_13
                2'h3: wave_d = ~wave_q;
                default: wave_d = wave_q;
            endcase
        end
        if (match_b && !cm_b_q) // RULE_11
        begin
            case (os_b)
                2'h1: wave_d = 1'b0; // RULE_13
                2'h2: wave_d = 1'b1;
                2'h3: wave_d = ~wave_q;
                default: wave_d = wave_d;
            endcase
        end

        if (do_write && w_lane0_q)
        begin
            if (rw_hit(aw_addr_q, `EBCT_OFS_COUNT))
            begin
                count_d = w_data_q[7:0]; // RULE_02
            end
            if (rw_hit(aw_addr_q, `EBCT_OFS_CONST_A))
            begin
                const_a_d = w_data_q[7:0]; // RULE_06
            end
            if (rw_hit(aw_addr_q, `EBCT_OFS_CONST_B))
            begin
                const_b_d = w_data_q[7:0]; // RULE_06
            end
            if (rw_hit(aw_addr_q, `EBCT_OFS_CTRL0))
            begin
                ctrl0_d = {2'h0, w_data_q[5:0]};
            end
            if (rw_hit(aw_addr_q, `EBCT_OFS_CSR))
            begin
                // Overflow flag is clear-only from software
                csr_d = {csr_q[7] & w_data_q[7], 3'h0, w_data_q[3:0]};
            end
            if (rw_hit(aw_addr_q, `EBCT_OFS_CTRL1))
            begin
                ctrl1_d = {7'h0, w_data_q[0]};
            end
            if (rw_hit(aw_addr_q, `EBCT_OFS_IRQ_STAT))
            begin
                stat_d = stat_q & ~w_data_q[2:0];
            end
            if (rw_hit(aw_addr_q, `EBCT_OFS_IRQ_MASK))
            begin
                mask_d = w_data_q[2:0];
            end
        end

        // Hardware sets win over software clears
        if (ovf_evt)
        begin
            csr_d[`EBCT_OVF_BIT] = 1'b1; // RULE_04
            stat_d[`EBCT_IRQ_OVF] = 1'b1;
        end
        if (match_a && !cm_a_q)
        begin
            stat_d[`EBCT_IRQ_CMA] = 1'b1;
        end
        if (match_b && !cm_b_q)
        begin
            stat_d[`EBCT_IRQ_CMB] = 1'b1;
        end
        irq_d = |(stat_d & mask_d);
    end

    // AXI4-Lite slave; every byte address decodes, unmapped ones read zero and answer OKAY
    always_comb
    begin
        aw_held_d = aw_held_q;
        aw_addr_d = aw_addr_q;
        w_held_d = w_held_q;
        w_data_d = w_data_q;
        w_lane0_d = w_lane0_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (i_awvalid && !aw_held_q)
        begin
            aw_held_d = 1'b1;
            aw_addr_d = i_awaddr;
        end
        if (i_wvalid && !w_held_q)
        begin
            w_held_d = 1'b1;
            w_data_d = i_wdata;
            w_lane0_d = i_wstrb[0];
        end
        if (do_write)
        begin
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = addr_ok ? 2'h0 : 2'h2;
        end
        if (bvalid_q && i_bready)
        begin
            bvalid_d = 1'b0;
        end
        if (rvalid_q && i_rready)
        begin
            rvalid_d = 1'b0;
        end
        if (i_arvalid && !rvalid_q)
        begin
            rvalid_d = 1'b1;
            rresp_d = 2'h0;
            case (i_araddr[7:2])
                `EBCT_OFS_COUNT >> 2: rdata_d = {24'h0, count_q}; // RULE_02
                `EBCT_OFS_CONST_A >> 2: rdata_d = {24'h0, const_a_q};
                `EBCT_OFS_CONST_B >> 2: rdata_d = {24'h0, const_b_q};
                `EBCT_OFS_CTRL0 >> 2: rdata_d = {24'h0, ctrl0_q};
                `EBCT_OFS_CSR >> 2: rdata_d = {24'h0, csr_q};
                `EBCT_OFS_CTRL1 >> 2: rdata_d = {24'h0, ctrl1_q};
                `EBCT_OFS_IRQ_STAT >> 2: rdata_d = {29'h0, stat_q};
                `EBCT_OFS_IRQ_MASK >> 2: rdata_d = {29'h0, mask_q};
                default: rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!t_rst_n)
        begin
            count_q <= `EBCT_COUNT_RESET; // RULE_05
            const_a_q <= `EBCT_CONST_RESET;
            const_b_q <= `EBCT_CONST_RESET;
            ctrl0_q <= 8'h00;
            csr_q <= 8'h00;
            ctrl1_q <= 8'h00;
            stat_q <= 3'h0;
            mask_q <= 3'h0;
            wave_q <= 1'b0;
            run_q <= EBCT_RUN_WAIT;
            cm_a_q <= 1'b0;
            cm_b_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else if (i_ce)
        begin
            count_q <= count_d;
            const_a_q <= const_a_d;
            const_b_q <= const_b_d;
            ctrl0_q <= ctrl0_d;
            csr_q <= csr_d;
            ctrl1_q <= ctrl1_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            wave_q <= wave_d;
            run_q <= run_d;
            cm_a_q <= cm_a_d;
            cm_b_q <= cm_b_d;
            irq_q <= irq_d;
        end
    end

    // Bus stays alive in low-power modes so software can still reach the reset registers
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_held_q <= 1'b0;
            w_data_q <= 32'h0;
            w_lane0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= 2'h0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            arready_q <= 1'b1;
        end
        else if (i_ce)
        begin
            aw_held_q <= aw_held_d;
            aw_addr_q <= aw_addr_d;
            w_held_q <= w_held_d;
            w_data_q <= w_data_d;
            w_lane0_q <= w_lane0_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            awready_q <= ~aw_held_d;
            wready_q <= ~w_held_d;
            arready_q <= ~rvalid_d;
        end
    end

    assign o_awready = awready_q;
    assign o_wready = wready_q;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_arready = arready_q;
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;
    assign o_wave_out_pin = wave_q;
    assign o_irq = irq_q;
endmodule : ebct_timer

// ===== tb/ebct_timer_sva.sv
`timescale 1ns/10ps
module ebct_timer_sva (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_low_power,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic [1:0] o_bresp,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0] o_rresp,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic o_wave_out_pin
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    property p_bvalid_hold;
        o_bvalid && !i_bready |=> o_bvalid;
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped before bready");
    property p_rdata_hold;
        o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read answer changed before rready");
    property p_resp_okay;
        (o_bvalid |-> o_bresp == 2'h0) and (o_rvalid |-> o_rresp == 2'h0);
    endproperty
    a_resp_okay: assert property (p_resp_okay) else $error("response not OKAY");
    property p_read_answer;
        i_arvalid && o_arready && i_ce |=> o_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("no read answer one cycle after address");
    property p_write_answer;
        i_awvalid && o_awready && i_wvalid && o_wready && i_ce |-> ##[1:2] o_bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("no write answer in time");
    property p_ar_block;
        o_rvalid |-> !o_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read address taken while answer pending");
    property p_upper_zero;
        o_rvalid |-> o_rdata[31:8] == 24'h000000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
    property p_low_power_wave;
        i_low_power && i_ce |=> !o_wave_out_pin;
    endproperty
    a_low_power_wave: assert property (p_low_power_wave) else $error("wave output not reset in low power");
endmodule : ebct_timer_sva

bind ebct_timer ebct_timer_sva ebct_timer_sva_i (.i_mclk, .i_rst_n, .i_ce, .i_low_power, .i_awvalid, .o_awready,
    .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
    .i_rready, .o_wave_out_pin);

// ===== tb/ebct_pin_model.sv
`timescale 1ns/10ps
module ebct_pin_model (
    input wire logic i_mclk,
    output logic o_ext_count_clock_pin,
    output logic o_ext_clear_pin,
    output logic o_start_trigger_pin
);
    initial
    begin
        o_ext_count_clock_pin = 1'b0;
        o_ext_clear_pin = 1'b0;
        o_start_trigger_pin = 1'b0;
    end

    // Six cycles a level keeps edges clear of the synchroniser's two-cycle spacing
    task automatic hold_level();
        repeat (6) @(posedge i_mclk);
    endtask : hold_level

    task automatic pulse(input int n);
        repeat (n)
        begin
            o_ext_count_clock_pin <= 1'b1;
            hold_level();
            o_ext_count_clock_pin <= 1'b0;
            hold_level();
        end
    endtask : pulse

    task automatic clear_pulse();
        o_ext_clear_pin <= 1'b1;
        hold_level();
        o_ext_clear_pin <= 1'b0;
        hold_level();
    endtask : clear_pulse

    task automatic trigger();
        o_start_trigger_pin <= ~o_start_trigger_pin;
        hold_level();
    endtask : trigger
endmodule : ebct_pin_model

// ===== tb/ebct_timer_tb.sv
`timescale 1ns/10ps
`include "ebct_params.svh"
module ebct_timer_tb;
    import ebct_pkg::*;
    logic i_mclk = 0, i_rst_n = 0, i_ce = 1, i_low_power = 0;
    logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
    logic [7:0] i_awaddr = 0, i_araddr = 0;
    logic [31:0] i_wdata = 0, o_rdata, rd, mx;
    logic [3:0] i_wstrb = 0;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_wave_out_pin, o_irq, hi, lo;
    logic [1:0] o_bresp, o_rresp;
    wire pin_clk, pin_clr, pin_trg;
    int fail_count = 0, checks = 0;
    int div [6] = '{2, 8, 64, 4, 16, 256};
    always #5 i_mclk = ~i_mclk;

    ebct_pin_model ebct_pin_model_i (.i_mclk, .o_ext_count_clock_pin(pin_clk), .o_ext_clear_pin(pin_clr),
        .o_start_trigger_pin(pin_trg));
    ebct_timer ebct_timer_i (.i_mclk, .i_rst_n, .i_ce, .i_low_power, .i_ext_count_clock_pin(pin_clk),
        .i_ext_clear_pin(pin_clr), .i_start_trigger_pin(pin_trg), .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
        .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
        .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_wave_out_pin, .o_irq);

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        logic done;
        done = 0;
        @(posedge i_mclk);
        i_awaddr <= a;
        i_wdata <= d;
        i_wstrb <= s;
        i_awvalid <= 1;
        i_wvalid <= 1;
        i_bready <= 1;
        for (int n = 0; n < 64 && !done; n++)
        begin
            @(posedge i_mclk);
            if (o_awready)
                i_awvalid <= 0;
            if (o_wready)
                i_wvalid <= 0;
            if (o_bvalid)
            begin
                i_bready <= 0;
                done = 1;
            end
        end
        check("write answer", done, 1);
        if (!done)
            complete_run();
    endtask : wr

    task automatic rchk(input string w, input logic [7:0] a, input logic [31:0] e, input logic cmp = 1);
        logic done;
        done = 0;
        @(posedge i_mclk);
        i_araddr <= a;
        i_arvalid <= 1;
        i_rready <= 1;
        for (int n = 0; n < 64 && !done; n++)
        begin
            @(posedge i_mclk);
            if (o_arready)
                i_arvalid <= 0;
            if (o_rvalid)
            begin
                rd = o_rdata;
                i_rready <= 0;
                done = 1;
            end
        end
        if (!done)
            check("read answer", done, 1);
        if (!done)
            complete_run();
        if (cmp)
            check(w, rd, e);
    endtask : rchk

    task automatic irq_chk(input logic e);
        // Interrupt output is registered behind the committed write
        repeat (2) @(posedge i_mclk);
        check("irq", o_irq, e);
    endtask : irq_chk

    initial
    begin
        repeat (20) @(posedge i_mclk);
        i_rst_n <= 1;
        rchk("count", `EBCT_OFS_COUNT, 0);
        rchk("const a", `EBCT_OFS_CONST_A, `EBCT_CONST_RESET);
        rchk("const b", `EBCT_OFS_CONST_B, `EBCT_CONST_RESET);
        wr(8'h20, 32'h55);
        rchk("unmapped", 8'h20, 0);
        wr(`EBCT_OFS_CONST_A, 32'h5a);
        wr(`EBCT_OFS_CONST_B, 32'ha5);
        wr(`EBCT_OFS_COUNT, 32'h3c);
        wr(`EBCT_OFS_COUNT, 32'h11, 4'h0);
        rchk("const a", `EBCT_OFS_CONST_A, 32'h5a);
        rchk("const b", `EBCT_OFS_CONST_B, 32'ha5);
        rchk("count", `EBCT_OFS_COUNT, 32'h3c);
        $display("test registers done");
        wr(`EBCT_OFS_COUNT, 32'hfd);
        wr(`EBCT_OFS_CTRL0, 32'h1);
        repeat (20) @(posedge i_mclk);
        wr(`EBCT_OFS_CTRL0, 32'h0);
        rchk("overflow flag", `EBCT_OFS_CSR, 32'h80);
        rchk("irq status", `EBCT_OFS_IRQ_STAT, 32'h1);
        irq_chk(0);
        wr(`EBCT_OFS_IRQ_MASK, 32'h1);
        irq_chk(1);
        wr(`EBCT_OFS_IRQ_STAT, 32'h1);
        irq_chk(0);
        wr(`EBCT_OFS_CSR, 32'h0);
        rchk("overflow cleared", `EBCT_OFS_CSR, 32'h0);
        $display("test overflow done");
        wr(`EBCT_OFS_CONST_A, 32'h9);
        wr(`EBCT_OFS_CONST_B, 32'h3);
        wr(`EBCT_OFS_CSR, {EBCT_OS_LOW, EBCT_OS_HIGH});
        for (int k = 0; k < 2; k++)
        begin
            wr(`EBCT_OFS_COUNT, 32'h0);
            wr(`EBCT_OFS_CTRL0, k ? {EBCT_CLR_B, 3'h1} : {EBCT_CLR_A, 3'h1});
            // Let the first match settle the level left over from the previous pass
            repeat (20) @(posedge i_mclk);
            {hi, lo, mx} = 0;
            repeat (80)
            begin
                @(posedge i_mclk);
                hi |= o_wave_out_pin;
                lo |= !o_wave_out_pin;
            end
            repeat (20)
            begin
                rchk("", `EBCT_OFS_COUNT, 0, 0);
                mx = (rd > mx) ? rd : mx;
            end
            wr(`EBCT_OFS_CTRL0, 32'h0);
            check("count ceiling", mx <= (k ? 3 : 9), 1);
            check("wave high", hi, k == 0);
            check("wave low", lo, 1);
        end
        $display("test compare done");
        for (int j = 0; j < 6; j++)
        begin
            wr(`EBCT_OFS_CTRL1, j / 3);
            wr(`EBCT_OFS_COUNT, 32'h0);
            wr(`EBCT_OFS_CTRL0, j % 3 + 1);
            repeat (32 * div[j]) @(posedge i_mclk);
            wr(`EBCT_OFS_CTRL0, 32'h0);
            rchk("", `EBCT_OFS_COUNT, 0, 0);
            check("rate", rd >= 31 && rd <= 34, 1);
        end
        wr(`EBCT_OFS_COUNT, 32'h0);
        wr(`EBCT_OFS_CTRL0, 32'h4);
        repeat (40) @(posedge i_mclk);
        rchk("stopped", `EBCT_OFS_COUNT, 0);
        $display("test clock select done");
        for (int m = 5; m < 8; m++)
        begin
            wr(`EBCT_OFS_CTRL0, m);
            ebct_pin_model_i.pulse(5);
            wr(`EBCT_OFS_CTRL0, 32'h0);
            rchk("ext count", `EBCT_OFS_COUNT, m == 5 ? 5 : (m == 6 ? 10 : 20));
        end
        wr(`EBCT_OFS_COUNT, 32'h0);
        wr(`EBCT_OFS_CTRL0, {EBCT_CLR_EXT, 3'h5});
        ebct_pin_model_i.pulse(4);
        rchk("ext count", `EBCT_OFS_COUNT, 4);
        ebct_pin_model_i.clear_pulse();
        rchk("ext clear", `EBCT_OFS_COUNT, 0);
        wr(`EBCT_OFS_CTRL0, 32'h0);
        wr(`EBCT_OFS_CTRL0, 32'h25);
        ebct_pin_model_i.pulse(3);
        rchk("trigger wait", `EBCT_OFS_COUNT, 0);
        ebct_pin_model_i.trigger();
        ebct_pin_model_i.pulse(3);
        rchk("triggered", `EBCT_OFS_COUNT, 3);
        $display("test pins done");
        @(posedge i_mclk);
        i_low_power <= 1;
        rchk("low power", `EBCT_OFS_COUNT, 0);
        @(posedge i_mclk);
        i_low_power <= 0;
        $display("test low power done");
        complete_run();
    end
endmodule : ebct_timer_tb
